// *** sfr_read_front.sv ***
// Multi-I/O read command front end of a serial flash, sampled on the system clock
// Behaviour
// - 3Bh takes 3 or 4 address bytes per extended_address_enable; 3Ch always 4.
// - Dual output read returns two bits per SCK falling edge on IO1 and IO0.
// - Dual output read waits zero or eight dummy cycles, chosen by latency_code.
// - Input lines are ignored during dummy cycles.
// - Reads start at any byte, address increments per byte and wraps to zero; the code wraps only past 32 bits, so 3-byte reads run on into bit 24.
// - 6Bh takes 3 or 4 address bytes per extended_address_enable; 6Ch always 4.
// - Quad output read returns one nibble per SCK falling edge on IO3-IO0.
// - Quad output read works only while quad_enable is one.
// - Quad output read inserts zero or eight dummy cycles per latency_code, inputs ignored meanwhile.
// - BBh takes 3 or 4 address bytes per extended_address_enable; BCh always 4.
// - Dual I/O read address arrives two bits per SCK rising edge.
// - Standard latency table: dual I/O read is opcode, address, latency only.
// - Enhanced latency table: opcode, address, four mode cycles, then latency.
// - Mode byte Axh makes the next frame a dual I/O read without opcode.
// - Only the mode byte upper nibble matters; the lower nibble is ignored.
// - Other mode values leave continuous mode at the next chip select rise.
// - A frame of eight or fewer clocks without valid sequence leaves continuous mode.
// - Dual I/O dummy count comes from latency_code of configuration_register_one.
// - extended_address_enable makes the 3-byte opcodes take a 4-byte address.
// - Every opcode arrives one bit per rising edge on IO0.
// - Chip select rising during data ends the read and releases the outputs.
// - Dummy cycles count falling to falling; zero means data on the first fall.
`timescale 1ns/1ps
`default_nettype none
module sfr_read_front
    import sfr_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz
    input wire logic sys_rst, // Async reset, active high
    input wire logic sck, // Serial clock pin from the host
    input wire logic cs_n, // Chip select pin, active low
    input wire logic [3:0] io_in, // IO3..IO0 pin levels
    output logic [3:0] io_out, // IO3..IO0 drive values
    output logic [3:0] io_oe, // IO3..IO0 drive enables, high drives
    input wire sfr_cfg_t cfg, // Configuration bits, system clock domain
    output logic mem_req_valid, // Array fetch request valid
    output logic [31:0] mem_req_addr, // Array fetch byte address
    input wire logic mem_req_ready, // Array accepts the request
    input wire logic mem_rsp_valid, // Array byte valid, in request order
    input wire logic [7:0] mem_rsp_data, // Array byte
    output logic mem_rsp_ready, // Buffer can take a byte
    output logic continuous_mode // Next frame starts with the address
);

    // Pin synchronisers: stage one feeds stage two only, stage three finds edges
    logic [5:0] pin_s1_ff;
    logic [5:0] pin_s2_ff;
    logic [1:0] pin_s3_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1_ff <= 6'h20;
            pin_s2_ff <= 6'h20;
            pin_s3_ff <= 2'h2;
        end
        else
        begin
            pin_s1_ff <= {cs_n, sck, io_in};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff[5:4];
        end
    end

    wire cs_s = pin_s2_ff[5];
    wire sck_s = pin_s2_ff[4];
    wire [3:0] io_s = pin_s2_ff[3:0];
    wire sck_rise = sck_s & ~pin_s3_ff[0];
    wire sck_fall = ~sck_s & pin_s3_ff[0];
    wire cs_rise = cs_s & ~pin_s3_ff[1];
    wire cs_fall = ~cs_s & pin_s3_ff[1];

    // Frame state
    sfr_state_t state_ff, nxt_state;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [31:0] sh_ff, nxt_sh;
    logic [7:0] mode_sh_ff, nxt_mode_sh;
    logic mode_keep_ff, nxt_mode_keep;
    logic mode_done_ff, nxt_mode_done;
    logic cont_ff, nxt_cont;
    logic [3:0] rise_tot_ff, nxt_rise_tot;
    logic dio_ff, nxt_dio;
    logic quad_ff, nxt_quad;
    logic addr4_ff, nxt_addr4;
    logic enh_ff, nxt_enh;
    logic [3:0] dummy_n_ff, nxt_dummy_n;
    logic [3:0] fall_cnt_ff, nxt_fall_cnt;
    logic [7:0] out_sh_ff, nxt_out_sh;
    logic [1:0] slot_ff, nxt_slot;
    logic [3:0] io_out_ff, nxt_io_out;
    logic [3:0] io_oe_ff, nxt_io_oe;
    logic addr_done;
    logic pop;

    // Opcode decode on the eighth rising edge
    wire [7:0] opcode = {sh_ff[6:0], io_s[0]};
    wire op_dout = (opcode == OP_DUAL_OUTPUT_READ) || (opcode == OP_DUAL_OUTPUT_READ_WIDE_ADDR);
    wire op_qout = (opcode == OP_QUAD_OUTPUT_READ) || (opcode == OP_QUAD_OUTPUT_READ_WIDE_ADDR);
    wire op_dio = (opcode == OP_DUAL_IO_READ) || (opcode == OP_DUAL_IO_READ_WIDE_ADDR);
    wire op_wide = (opcode == OP_DUAL_OUTPUT_READ_WIDE_ADDR) || (opcode == OP_QUAD_OUTPUT_READ_WIDE_ADDR)
        || (opcode == OP_DUAL_IO_READ_WIDE_ADDR);
    wire op_addr4 = op_wide | cfg.extended_address_enable;
    wire op_quad_blocked = op_qout & ~cfg.quad_enable;

    // Dummy count selection from the latency code
    wire [3:0] lat_pos = {cfg.latency_code, 2'b00};
    wire [3:0] dmy_out = DMY_OUT_TBL[lat_pos +: 4];
    wire [3:0] dmy_dio = cfg.enhanced_latency_table ? DMY_DIO_ENH_TBL[lat_pos +: 4]
        : DMY_DIO_STD_TBL[lat_pos +: 4];

    // Address phase length in rising edges
    wire [5:0] addr_bits = addr4_ff ? ADDR4_BITS : ADDR3_BITS;
    wire [5:0] addr_rises = dio_ff ? {1'b0, addr_bits[5:1]} : addr_bits;
    wire addr_last = cnt_ff == 6'(addr_rises - 6'h01);
    wire [31:0] addr_shift = dio_ff ? {sh_ff[29:0], io_s[1], io_s[0]} : {sh_ff[30:0], io_s[0]};
    wire [31:0] addr_cap = addr4_ff ? addr_shift : {8'h00, addr_shift[23:0]};
    wire [7:0] mode_shift = {mode_sh_ff[5:0], io_s[1], io_s[0]};
    wire short_frame = rise_tot_ff <= CONT_ABORT_RISES;

    // Outgoing byte source and slot handling
    wire [7:0] buf_data;
    wire buf_valid;
    wire [7:0] load_byte = buf_valid ? buf_data : 8'h00;
    wire [1:0] slot_last = quad_ff ? SLOT_LAST_QUAD : SLOT_LAST_DUAL;
    wire [7:0] shifted_byte = quad_ff ? {out_sh_ff[3:0], 4'h0} : {out_sh_ff[5:0], 2'b00};

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_mode_sh = mode_sh_ff;
        nxt_mode_keep = mode_keep_ff;
        nxt_mode_done = mode_done_ff;
        nxt_cont = cont_ff;
        nxt_rise_tot = rise_tot_ff;
        nxt_dio = dio_ff;
        nxt_quad = quad_ff;
        nxt_addr4 = addr4_ff;
        nxt_enh = enh_ff;
        nxt_dummy_n = dummy_n_ff;
        nxt_fall_cnt = fall_cnt_ff;
        nxt_out_sh = out_sh_ff;
        nxt_slot = slot_ff;
        nxt_io_out = io_out_ff;
        nxt_io_oe = io_oe_ff;
        addr_done = 1'b0;
        pop = 1'b0;
        if (cs_rise)
        begin
            nxt_state = ST_IDLE;
            nxt_io_oe = OE_NONE;
            if (mode_done_ff)
            begin
                nxt_cont = mode_keep_ff;
            end
            else if (cont_ff && (short_frame || state_ff == ST_MODE))
            begin
                nxt_cont = 1'b0;
            end
        end
        else if (cs_fall)
        begin
            nxt_cnt = 6'h00;
            nxt_sh = 32'h0000_0000;
            nxt_rise_tot = 4'h0;
            nxt_mode_done = 1'b0;
            nxt_mode_keep = 1'b0;
            nxt_io_oe = OE_NONE;
            if (cont_ff)
            begin
                // Continuous frame: same dual I/O read, opcode skipped
                nxt_state = ST_ADDR;
                nxt_dio = 1'b1;
                nxt_quad = 1'b0;
                nxt_enh = 1'b1;
                nxt_dummy_n = dmy_dio;
            end
            else
            begin
                nxt_state = ST_OPCODE;
            end
        end
        else if (!cs_s && sck_rise)
        begin
            nxt_rise_tot = (rise_tot_ff == RISE_SAT) ? RISE_SAT : 4'(rise_tot_ff + 4'h1);
            unique case (state_ff)
                ST_OPCODE:
                begin
                    nxt_sh = {sh_ff[30:0], io_s[0]};
                    nxt_cnt = 6'(cnt_ff + 6'h01);
                    if (cnt_ff == 6'(OPCODE_BITS - 6'h01))
                    begin
                        nxt_cnt = 6'h00;
                        nxt_sh = 32'h0000_0000;
                        nxt_dio = op_dio;
                        nxt_quad = op_qout;
                        nxt_addr4 = op_addr4;
                        nxt_enh = op_dio & cfg.enhanced_latency_table;
                        nxt_dummy_n = op_dio ? dmy_dio : dmy_out;
                        nxt_state = ((op_dout || op_qout || op_dio) && !op_quad_blocked) ? ST_ADDR : ST_IGNORE;
                    end
                end
                ST_ADDR:
                begin
                    nxt_sh = addr_shift;
                    nxt_cnt = 6'(cnt_ff + 6'h01);
                    if (addr_last)
                    begin
                        addr_done = 1'b1;
                        nxt_cnt = 6'h00;
                        nxt_fall_cnt = 4'h0;
                        nxt_state = enh_ff ? ST_MODE : ST_DUMMY;
                    end
                end
                ST_MODE:
                begin
                    nxt_mode_sh = mode_shift;
                    nxt_cnt = 6'(cnt_ff + 6'h01);
                    if (cnt_ff == 6'(MODE_RISES - 6'h01))
                    begin
                        nxt_mode_keep = mode_shift[7:4] == MODE_KEEP_NIBBLE;
                        nxt_mode_done = 1'b1;
                        nxt_fall_cnt = 4'h0;
                        nxt_state = ST_DUMMY;
                    end
                end
                default:
                begin
                    // Dummy, data, idle and ignored frames sample nothing
                    nxt_cnt = cnt_ff;
                end
            endcase
        end
        else if (!cs_s && sck_fall)
        begin
            if (state_ff == ST_DUMMY)
            begin
                if (fall_cnt_ff == dummy_n_ff)
                begin
                    // First data on the fall that closes the last dummy cycle
                    nxt_state = ST_DATA;
                    pop = buf_valid;
                    nxt_out_sh = load_byte;
                    nxt_slot = 2'h0;
                    nxt_io_oe = quad_ff ? OE_QUAD : OE_DUAL;
                    nxt_io_out = quad_ff ? load_byte[7:4] : {2'b00, load_byte[7:6]};
                end
                else
                begin
                    nxt_fall_cnt = 4'(fall_cnt_ff + 4'h1);
                end
            end
            else if (state_ff == ST_DATA)
            begin
                if (slot_ff == slot_last)
                begin
                    pop = buf_valid;
                    nxt_out_sh = load_byte;
                    nxt_slot = 2'h0;
                    nxt_io_out = quad_ff ? load_byte[7:4] : {2'b00, load_byte[7:6]};
                end
                else
                begin
                    nxt_out_sh = shifted_byte;
                    nxt_slot = 2'(slot_ff + 2'h1);
                    nxt_io_out = quad_ff ? shifted_byte[7:4] : {2'b00, shifted_byte[7:6]};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 6'h00;
            sh_ff <= 32'h0000_0000;
            mode_sh_ff <= 8'h00;
            mode_keep_ff <= 1'b0;
            mode_done_ff <= 1'b0;
            cont_ff <= 1'b0;
            rise_tot_ff <= 4'h0;
            dio_ff <= 1'b0;
            quad_ff <= 1'b0;
            addr4_ff <= 1'b0;
            enh_ff <= 1'b0;
            dummy_n_ff <= 4'h0;
            fall_cnt_ff <= 4'h0;
            out_sh_ff <= 8'h00;
            slot_ff <= 2'h0;
            io_out_ff <= 4'h0;
            io_oe_ff <= OE_NONE;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            mode_sh_ff <= nxt_mode_sh;
            mode_keep_ff <= nxt_mode_keep;
            mode_done_ff <= nxt_mode_done;
            cont_ff <= nxt_cont;
            rise_tot_ff <= nxt_rise_tot;
            dio_ff <= nxt_dio;
            quad_ff <= nxt_quad;
            addr4_ff <= nxt_addr4;
            enh_ff <= nxt_enh;
            dummy_n_ff <= nxt_dummy_n;
            fall_cnt_ff <= nxt_fall_cnt;
            out_sh_ff <= nxt_out_sh;
            slot_ff <= nxt_slot;
            io_out_ff <= nxt_io_out;
            io_oe_ff <= nxt_io_oe;
        end
    end

    // Array prefetch: keeps the buffer topped up, stale bytes of a closed frame are dropped
    logic fetch_on_ff;
    logic [31:0] fetch_addr_ff;
    logic req_valid_ff;
    logic [31:0] req_addr_ff;
    logic req_stale_ff;
    logic [1:0] outst_ff;
    logic [1:0] drop_ff;
    wire [1:0] buf_level;
    wire buf_in_ready;
    wire req_take = req_valid_ff & mem_req_ready;
    wire rsp_take = mem_rsp_valid & buf_in_ready;
    wire rsp_drop = rsp_take & (drop_ff != 2'h0);
    wire [1:0] nxt_outst = 2'(outst_ff + {1'b0, req_take} - {1'b0, rsp_take});
    wire [2:0] live = 3'({1'b0, buf_level} + {1'b0, outst_ff} - {1'b0, drop_ff});
    wire issue = fetch_on_ff & ~req_valid_ff & ~cs_rise & (live < {1'b0, FETCH_LIMIT});
    wire [1:0] nxt_drop = cs_rise ? nxt_outst
        : 2'(drop_ff - {1'b0, rsp_drop} + {1'b0, req_take & req_stale_ff});

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fetch_on_ff <= 1'b0;
            fetch_addr_ff <= 32'h0000_0000;
            req_valid_ff <= 1'b0;
            req_addr_ff <= 32'h0000_0000;
            req_stale_ff <= 1'b0;
            outst_ff <= 2'h0;
            drop_ff <= 2'h0;
        end
        else
        begin
            outst_ff <= nxt_outst;
            drop_ff <= nxt_drop;
            if (cs_rise)
            begin
                fetch_on_ff <= 1'b0;
            end
            else if (addr_done)
            begin
                fetch_on_ff <= 1'b1;
                fetch_addr_ff <= addr_cap;
            end
            else if (issue)
            begin
                fetch_addr_ff <= 32'(fetch_addr_ff + 32'h0000_0001);
            end
            if (issue && !addr_done)
            begin
                req_valid_ff <= 1'b1;
                req_addr_ff <= fetch_addr_ff;
                req_stale_ff <= 1'b0;
            end
            else if (req_take)
            begin
                req_valid_ff <= 1'b0;
            end
            if (cs_rise && req_valid_ff && !req_take)
            begin
                req_stale_ff <= 1'b1;
            end
        end
    end

    sfr_pair_buf u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(cs_rise),
        .in_valid(mem_rsp_valid && drop_ff == 2'h0),
        .in_data(mem_rsp_data),
        .in_ready(buf_in_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(pop),
        .level(buf_level)
    );

    assign io_out = io_out_ff;
    assign io_oe = io_oe_ff;
    assign mem_req_valid = req_valid_ff;
    assign mem_req_addr = req_addr_ff;
    assign mem_rsp_ready = buf_in_ready;
    assign continuous_mode = cont_ff;

endmodule
`default_nettype wire

// *** sfr_pkg.sv ***
// Shared constants, commands and carriers of the multi-I/O read front end
package sfr_pkg;

    // Read command opcodes
    localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3B;
    localparam logic [7:0] OP_DUAL_OUTPUT_READ_WIDE_ADDR = 8'h3C;
    localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_OUTPUT_READ_WIDE_ADDR = 8'h6C;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO_READ_WIDE_ADDR = 8'hBC;

    // Phase lengths in SCK rising edges
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] ADDR3_BITS = 6'h18;
    localparam logic [5:0] ADDR4_BITS = 6'h20;
    localparam logic [5:0] MODE_RISES = 6'h04;
    localparam logic [3:0] CONT_ABORT_RISES = 4'h8;
    localparam logic [3:0] RISE_SAT = 4'hF;

    // Upper nibble of the mode byte that keeps continuous mode
    localparam logic [3:0] MODE_KEEP_NIBBLE = 4'hA;

    // Dummy counts per latency code, one nibble per code, code 0 in the low nibble
    localparam logic [15:0] DMY_OUT_TBL = 16'h0888;
    localparam logic [15:0] DMY_DIO_STD_TBL = 16'h0444;
    localparam logic [15:0] DMY_DIO_ENH_TBL = 16'h0654;

    // Data slots per byte on the falling edges
    localparam logic [1:0] SLOT_LAST_DUAL = 2'h3;
    localparam logic [1:0] SLOT_LAST_QUAD = 2'h1;

    // Output enable patterns
    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hF;

    // Buffer geometry
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 8;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] FETCH_LIMIT = 2'h2;

    // Configuration carried in from the register side
    typedef struct packed {
        logic extended_address_enable;
        logic quad_enable;
        logic [1:0] latency_code;
        logic enhanced_latency_table;
    } sfr_cfg_t;

    // Frame state, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_OPCODE = 7'b0000010,
        ST_ADDR = 7'b0000100,
        ST_MODE = 7'b0001000,
        ST_DUMMY = 7'b0010000,
        ST_DATA = 7'b0100000,
        ST_IGNORE = 7'b1000000
    } sfr_state_t;

endpackage

// *** sfr_pair_buf.sv ***
// Two-entry byte buffer between the array fetch and the output shifter
`timescale 1ns/1ps
`default_nettype none
module sfr_pair_buf
    import sfr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic flush, // Drop all entries
    input wire logic in_valid, // Write side valid
    input wire logic [BUF_WIDTH-1:0] in_data, // Write side byte
    output logic in_ready, // Write side ready, registered
    output logic out_valid, // Read side valid
    output logic [BUF_WIDTH-1:0] out_data, // Read side byte
    input wire logic out_ready, // Read side pop
    output logic [1:0] level // Entries held
);

    logic [BUF_WIDTH-1:0] mem_ff [BUF_DEPTH];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] cnt_ff;
    logic in_ready_ff;
    wire push = in_valid & in_ready_ff;
    wire pop = out_ready & (cnt_ff != 2'h0);
    wire [1:0] nxt_cnt = flush ? 2'h0 : 2'(cnt_ff + {1'b0, push} - {1'b0, pop});

    assign in_ready = in_ready_ff;
    assign out_valid = cnt_ff != 2'h0;
    assign out_data = mem_ff[rd_ptr_ff];
    assign level = cnt_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
            in_ready_ff <= 1'b0;
        end
        else
        begin
            wr_ptr_ff <= flush ? 1'b0 : wr_ptr_ff ^ push;
            rd_ptr_ff <= flush ? 1'b0 : rd_ptr_ff ^ pop;
            cnt_ff <= nxt_cnt;
            in_ready_ff <= nxt_cnt != BUF_FULL;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push && !flush)
        begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

endmodule
`default_nettype wire

// *** sfr_read_front_monitor.sv ***
// Port checker for the multi-I/O read front end
`timescale 1ns/1ps
`default_nettype none
module sfr_read_front_monitor
    import sfr_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic sck, // Serial clock
    input wire logic cs_n, // Select
    input wire logic [3:0] io_out, // Drive values
    input wire logic [3:0] io_oe, // Drive enables
    input wire sfr_cfg_t cfg, // Configuration
    input wire logic mem_req_valid, // Fetch valid
    input wire logic [31:0] mem_req_addr, // Fetch address
    input wire logic mem_req_ready, // Fetch ready
    input wire logic continuous_mode // Continuous flag
);
    logic [31:0] last_ff;
    logic seen_ff;
    // Last fetch address inside the current frame
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            seen_ff <= 1'b0;
        else if (cs_n)
            seen_ff <= 1'b0;
        else if (mem_req_valid && mem_req_ready)
            seen_ff <= 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (mem_req_valid && mem_req_ready)
            last_ff <= mem_req_addr;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence cs_rise;
        !cs_n ##1 cs_n;
    endsequence
    sequence fetch;
        mem_req_valid && mem_req_ready && seen_ff;
    endsequence
    AST_OE_SHAPE: assert property (io_oe == OE_NONE || io_oe == OE_DUAL || io_oe == OE_QUAD)
        else $error("io_oe pattern");
    AST_DUAL_HIGH: assert property (io_oe == OE_DUAL |-> io_out[3:2] == 2'h0)
        else $error("dual upper lines");
    AST_QUAD_GATE: assert property (io_oe == OE_QUAD |-> cfg.quad_enable)
        else $error("quad without enable");
    AST_OE_ON_LOW: assert property ($rose(io_oe != OE_NONE) |-> !sck && !cs_n)
        else $error("drive start");
    AST_OUT_ON_FALL: assert property (io_oe != OE_NONE && $changed(io_out) |-> !sck)
        else $error("data change");
    AST_RELEASE: assert property (cs_rise |-> ##[1:6] io_oe == OE_NONE)
        else $error("no release");
    AST_FETCH_STEP: assert property (fetch |-> mem_req_addr == last_ff + 32'h1)
        else $error("address step");
    AST_CONT_IDLE: assert property ($changed(continuous_mode) |-> cs_n && $past(cs_n))
        else $error("continuous change");
endmodule
bind sfr_read_front sfr_read_front_monitor u_mon (.clk, .sys_rst, .sck, .cs_n, .io_out, .io_oe, .cfg,
    .mem_req_valid, .mem_req_addr, .mem_req_ready, .continuous_mode);
`default_nettype wire

// *** sfr_host.sv ***
// Host controller model driving select, SCK and the I/O lines
`timescale 1ns/1ps
`default_nettype none
module sfr_host
(
    output logic sck, // Serial clock
    output logic cs_n, // Select
    output logic [3:0] io_drv, // Drive values
    output logic [3:0] io_en, // Drive enables
    input wire logic [3:0] io // Line levels
);
    localparam realtime HALF = 62.5;
    logic [7:0] rx [0:7];
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_drv = 4'h0;
        io_en = 4'h0;
    end
    task automatic cyc(input logic [3:0] v, input logic [3:0] en);
    begin
        sck = 1'b0;
        io_drv = v;
        io_en = en;
        #HALF;
        sck = 1'b1;
        #HALF;
    end
    endtask
    task automatic xfer(input logic [7:0] op, input bit so, input logic [31:0] a, input int nab, input int aw,
        input bit sm, input logic [7:0] m, input int dmy, input int dw, input int n);
        logic [7:0] b;
    begin
        cs_n = 1'b0;
        if (so)
            for (int i = 7; i >= 0; i--)
                cyc({3'h0, op[i]}, 4'h1);
        for (int i = nab * 8 - aw; i >= 0; i -= aw)
            cyc(aw == 2 ? {2'h0, a[i+1], a[i]} : {3'h0, a[i]}, aw == 2 ? 4'h3 : 4'h1);
        if (sm)
            for (int i = 6; i >= 0; i -= 2)
                cyc({2'h0, m[i+1], m[i]}, i > 2 ? 4'h3 : 4'h0);
        for (int k = 0; k < dmy; k++)
            cyc(4'h5 ^ k[3:0], 4'hF);
        for (int j = 0; j < n; j++)
        begin
            for (int s = 0; s < 8; s += dw)
            begin
                sck = 1'b0;
                io_en = 4'h0;
                #HALF;
                b = dw == 4 ? {b[3:0], io} : {b[5:0], io[1:0]};
                sck = 1'b1;
                #HALF;
            end
            rx[j] = b;
        end
        cs_n = 1'b1;
        #HALF;
        sck = 1'b0;
        #(HALF * 3);
    end
    endtask
endmodule
`default_nettype wire

// *** sfr_read_front_tb.sv ***
// Self-checking bench for the multi-I/O read front end
`timescale 1ns/1ps
`default_nettype none
module sfr_read_front_tb
    import sfr_pkg::*;
;
    logic clk, sys_rst, tgl, sck, cs_n, mem_req_valid, mem_req_ready, mem_rsp_valid, mem_rsp_ready, continuous_mode;
    logic [3:0] io, io_out, io_oe, h_drv, h_en;
    logic [31:0] mem_req_addr;
    logic [7:0] mem_rsp_data;
    sfr_cfg_t cfg;
    int fail_count;
    int check_count;
    bit oe_seen;
    // Released lines show a toggling level instead of a stale value
    assign io = (io_oe & io_out) | (~io_oe & h_en & h_drv) | (~io_oe & ~h_en & {4{tgl}});
    assign mem_req_ready = !mem_rsp_valid;
    sfr_host host (.sck, .cs_n, .io_drv(h_drv), .io_en(h_en), .io);
    sfr_read_front DUT (.clk, .sys_rst, .sck, .cs_n, .io_in(io), .io_out, .io_oe, .cfg, .mem_req_valid,
        .mem_req_addr, .mem_req_ready, .mem_rsp_valid, .mem_rsp_data, .mem_rsp_ready, .continuous_mode);
    function automatic logic [7:0] dat(input logic [31:0] a);
        return a[7:0] ^ a[31:24] ^ 8'hA5;
    endfunction
    function automatic int dn(input logic [15:0] t, input int l);
        return int'(t[l*4 +: 4]);
    endfunction
    // Array model: one byte a cycle after each accepted fetch, held while stalled
    always @(posedge clk)
    begin
        tgl <= ~tgl;
        if (mem_rsp_valid && mem_rsp_ready)
            mem_rsp_valid <= 1'b0;
        if (mem_req_valid && mem_req_ready)
        begin
            mem_rsp_valid <= 1'b1;
            mem_rsp_data <= dat(mem_req_addr);
        end
        if (io_oe != OE_NONE)
            oe_seen <= 1'b1;
    end
    task automatic summarize();
    begin
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task automatic setc(input logic e, input logic q, input logic [1:0] l, input logic h);
    begin
        @(posedge clk);
        cfg <= '{e, q, l, h};
        @(posedge clk);
    end
    endtask
    task automatic rd(input logic [7:0] op, input bit so, input logic [31:0] a, input int nab, input int aw,
        input bit sm, input logic [7:0] m, input int dmy, input int dw, input int n);
        logic [31:0] e;
    begin
        // Start just off a clock edge so pin changes never race the samplers
        @(posedge clk);
        #1;
        host.xfer(op, so, a, nab, aw, sm, m, dmy, dw, n);
        e = nab == 3 ? {8'h00, a[23:0]} : a;
        for (int j = 0; j < n; j++)
            chk("data", {24'h0, dat(e + j)}, {24'h0, host.rx[j]});
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #400us;
        fail_count++;
        summarize();
    end
    initial
    begin
        sys_rst = 1'b1;
        tgl = 1'b0;
        cfg = '0;
        mem_rsp_valid = 1'b0;
        mem_rsp_data = 8'h00;
        fail_count = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        setc(0, 1, 3, 0);
        rd(OP_DUAL_OUTPUT_READ, 1, 32'h77ABCDFE, 3, 1, 0, 0, dn(DMY_OUT_TBL, 3), 2, 3);
        rd(OP_DUAL_OUTPUT_READ_WIDE_ADDR, 1, 32'hFFFFFFFE, 4, 1, 0, 0, 0, 2, 4);
        setc(1, 1, 0, 0);
        rd(OP_DUAL_OUTPUT_READ, 1, 32'h89ABCDEF, 4, 1, 0, 0, dn(DMY_OUT_TBL, 0), 2, 2);
        rd(OP_QUAD_OUTPUT_READ, 1, 32'h1234567F, 4, 1, 0, 0, dn(DMY_OUT_TBL, 0), 4, 3);
        setc(0, 1, 1, 0);
        rd(OP_QUAD_OUTPUT_READ_WIDE_ADDR, 1, 32'hC0000001, 4, 1, 0, 0, dn(DMY_OUT_TBL, 1), 4, 2);
        setc(0, 1, 2, 0);
        rd(OP_DUAL_IO_READ, 1, 32'h00ABCDEF, 3, 2, 0, 0, dn(DMY_DIO_STD_TBL, 2), 2, 3);
        setc(0, 1, 1, 1);
        rd(OP_DUAL_IO_READ_WIDE_ADDR, 1, 32'h76543210, 4, 2, 1, 8'hA5, dn(DMY_DIO_ENH_TBL, 1), 2, 2);
        chk("continuous_mode", 1, continuous_mode);
        rd(8'h00, 0, 32'h01020304, 4, 2, 1, 8'h3A, dn(DMY_DIO_ENH_TBL, 1), 2, 2);
        chk("continuous_mode", 0, continuous_mode);
        rd(OP_DUAL_IO_READ, 1, 32'h00000010, 3, 2, 1, 8'hAF, dn(DMY_DIO_ENH_TBL, 1), 2, 1);
        chk("continuous_mode", 1, continuous_mode);
        rd(8'hFF, 1, 0, 0, 1, 0, 0, 0, 2, 0);
        chk("continuous_mode", 0, continuous_mode);
        setc(0, 0, 3, 0);
        #1 oe_seen = 1'b0;
        host.xfer(OP_QUAD_OUTPUT_READ, 1, 32'h00000100, 3, 1, 0, 0, 0, 4, 2);
        chk("quad refused", 0, oe_seen);
        summarize();
    end
endmodule
`default_nettype wire
